// >>> common/cpu_core_cfg.svh
// cpu_core_cfg.svh: reset values, field positions and opcodes of the core
// assumes inclusion by bare name from the core and flag unit sources
`ifndef CPU_CORE_CFG_SVH
`define CPU_CORE_CFG_SVH
`define PC_RST_VAL 16'h0000
`define SP_RST_VAL 16'h0000
`define REG_RST_VAL 8'h00
`define FLAG_RST_VAL 5'h00
`define IDX_ACC 3'h7
`define IDX_H 3'h4
`define IDX_L 3'h5
`define IDX_MEM 3'h6
`define FLG_CY 0
`define FLG_P 1
`define FLG_AC 2
`define FLG_Z 3
`define FLG_S 4
`define ALU_ADD 3'h0
`define ALU_SUB 3'h2
`define ALU_CMP 3'h7
`define ALU_IMM_SRC 3'h6
`define RST_SRC 3'h7
`define OPC_LDA 8'h3a
`define OPC_STA 8'h32
`define OPC_JMP 8'hc3
`define OPC_PCHL 8'he9
`define LDAX_LOW 4'ha
`define STAX_LOW 4'h2
`endif

// >>> common/cpu_core_pkg.sv
// cpu_core_pkg: shared types of the byte-wide processor core
// assumes nothing beyond a SystemVerilog compiler
package cpu_core_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [15:0] addr_t;
  // processor states, gray order t1 t2 t3 t4
  typedef enum logic [1:0] {st_t1 = 2'b00, st_t2 = 2'b01, st_t3 = 2'b11, st_t4 = 2'b10} tstate_e;
  // machine cycle kinds
  typedef enum logic [1:0] {k_fetch = 2'b00, k_read = 2'b01, k_write = 2'b10} cycle_e;
endpackage

// >>> src/flag_alu.sv
// flag_alu: 8-bit add and subtract with the five condition flags
// assumes a purely combinational use, sampled by the core on its clock
`include "cpu_core_cfg.svh"

module flag_alu (
  // operands
  input wire cpu_core_pkg::byte_t a_i,
  input wire cpu_core_pkg::byte_t b_i,
  input wire logic sub_i,
  // result and flags
  output cpu_core_pkg::byte_t res_o,
  output logic [4:0] flags_o
);
  import cpu_core_pkg::*;

  logic [7:0] b_x;
  logic [8:0] sum;
  logic [4:0] nib;

  // subtraction as a + ~b + 1, so one adder serves both
  assign b_x = sub_i ? ~b_i : b_i;
  assign sum = {1'b0, a_i} + {1'b0, b_x} + {8'h00, sub_i};
  assign nib = {1'b0, a_i[3:0]} + {1'b0, b_x[3:0]} + {4'h0, sub_i};
  assign res_o = sum[7:0];

  // flag rules on the 8-bit result
  assign flags_o[`FLG_Z] = (sum[7:0] == 8'h00);
  assign flags_o[`FLG_S] = sum[7];
  assign flags_o[`FLG_P] = ~^sum[7:0];
  // borrow is the inverted carry of the complement add
  assign flags_o[`FLG_CY] = sum[8] ^ sub_i;
  assign flags_o[`FLG_AC] = nib[4];
endmodule

// >>> src/cpu_data_move.sv
// cpu_data_move: processor core for data moves, direct branches and flags
// assumes byte memory that returns read data by the end of state t3
`include "cpu_core_cfg.svh"

module cpu_data_move (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  // processor bus
  output cpu_core_pkg::addr_t MEM_ADDR_O,
  output logic MEM_RD_O,
  output logic MEM_WR_O,
  output cpu_core_pkg::byte_t MEM_WDATA_O,
  input wire cpu_core_pkg::byte_t MEM_RDATA_I,
  // visible state
  output logic [4:0] FLAGS_O,
  output cpu_core_pkg::byte_t ACC_O
);
  import cpu_core_pkg::*;

  tstate_e st_r, st_nxt;
  cycle_e kind_r, nk;
  logic [1:0] mc_r;
  byte_t ir_r, lo_r, adr_lo;
  addr_t pc_r, sp_r, adr_r, na, pc_val;
  byte_t wd_r, nd, rf_val, src_val, din, alu_b, alu_res;
  byte_t rf_r [0:7];
  logic [4:0] flag_r, alu_flags;
  logic [2:0] dst, src, rf_idx;
  logic cyc_end, pc_up, pc_ld, sp_dec, rf_we, fl_we, lo_we;
  logic is_mov, mov_rr, mov_ld, mov_st, is_mvi, is_lda, is_sta, is_jmp;
  logic is_pchl, is_ldax, is_stax, is_rst, alu_ok, alu_reg, alu_imm;
  logic alu_go, abs16, is_xfer, src_mem;
  addr_t hl, rp_adr;

  // opcode field decode; the field value is the register index
  assign dst = ir_r[5:3];
  assign src = ir_r[2:0];
  assign src_mem = (src == `IDX_MEM);
  assign is_mov = (ir_r[7:6] == 2'b01) && !(dst == `IDX_MEM && src_mem);
  assign mov_rr = is_mov && dst != `IDX_MEM && !src_mem;
  assign mov_ld = is_mov && src_mem;
  assign mov_st = is_mov && dst == `IDX_MEM;
  assign is_mvi = (ir_r[7:6] == 2'b00) && src_mem;
  assign is_lda = (ir_r == `OPC_LDA);
  assign is_sta = (ir_r == `OPC_STA);
  assign is_jmp = (ir_r == `OPC_JMP);
  assign is_pchl = (ir_r == `OPC_PCHL);
  assign is_ldax = (ir_r[7:5] == 3'b000) && (ir_r[3:0] == `LDAX_LOW);
  assign is_stax = (ir_r[7:5] == 3'b000) && (ir_r[3:0] == `STAX_LOW);
  assign is_rst = (ir_r[7:6] == 2'b11) && (src == `RST_SRC);
  assign alu_ok = dst == `ALU_ADD || dst == `ALU_SUB || dst == `ALU_CMP;
  assign alu_reg = (ir_r[7:6] == 2'b10) && alu_ok;
  assign alu_imm = (ir_r[7:6] == 2'b11) && src == `ALU_IMM_SRC && alu_ok;
  assign abs16 = is_lda || is_sta || is_jmp;
  assign is_xfer = is_mov || is_mvi || is_lda || is_sta || is_ldax || is_stax;

  // operand sources; pair addresses put the first register on top
  assign hl = {rf_r[`IDX_H], rf_r[`IDX_L]};
  assign rp_adr = {rf_r[{1'b0, ir_r[4], 1'b0}], rf_r[{1'b0, ir_r[4], 1'b1}]};
  assign src_val = rf_r[src];
  assign din = MEM_RDATA_I;
  assign adr_lo = lo_r;
  assign alu_b = (mc_r == 2'd0) ? src_val : din;
  assign alu_go = (alu_reg && !src_mem && mc_r == 2'd0)
                  || ((alu_imm || (alu_reg && src_mem)) && mc_r == 2'd1);
  // fetch runs four states, read and write cycles three
  assign cyc_end = (st_r == st_t4) || (st_r == st_t3 && kind_r != k_fetch);

  flag_alu flag_alu_inst (
    .a_i(rf_r[`IDX_ACC]),
    .b_i(alu_b),
    .sub_i(dst != `ALU_ADD),
    .res_o(alu_res),
    .flags_o(alu_flags)
  );

  // state walk through one machine cycle
  always_comb
  begin
    unique case (st_r)
      st_t1: st_nxt = st_t2;
      st_t2: st_nxt = st_t3;
      st_t3: st_nxt = (kind_r == k_fetch) ? st_t4 : st_t1;
      st_t4: st_nxt = st_t1;
    endcase
  end

  // what the ending machine cycle does and which cycle comes next
  always_comb
  begin
    nk = k_fetch;
    na = pc_r;
    nd = 8'h00;
    pc_up = 1'b0;
    pc_ld = 1'b0;
    pc_val = pc_r;
    sp_dec = 1'b0;
    rf_we = 1'b0;
    rf_idx = dst;
    rf_val = din;
    fl_we = 1'b0;
    lo_we = 1'b0;
    if (mov_rr)
    begin
      rf_we = 1'b1;
      rf_val = src_val;
    end
    // immediate bytes come from the instruction stream, low byte first
    if (((is_mvi || alu_imm) && mc_r == 2'd0) || (abs16 && mc_r != 2'd2 && mc_r != 2'd3))
    begin
      nk = k_read;
      pc_up = 1'b1;
    end
    lo_we = abs16 && mc_r == 2'd1;
    if ((mov_ld || (alu_reg && src_mem)) && mc_r == 2'd0)
    begin
      nk = k_read;
      na = hl;
    end
    if ((mov_ld || is_ldax) && mc_r == 2'd1)
    begin
      rf_we = 1'b1;
      rf_idx = mov_ld ? dst : `IDX_ACC;
    end
    if (mov_st && mc_r == 2'd0)
    begin
      nk = k_write;
      na = hl;
      nd = src_val;
    end
    if (is_mvi && mc_r == 2'd1)
    begin
      if (dst == `IDX_MEM)
      begin
        nk = k_write;
        na = hl;
        nd = din;
      end
      else
      begin
        rf_we = 1'b1;
      end
    end
    if (abs16 && mc_r == 2'd2)
    begin
      // second byte low half, third byte high half
      pc_ld = is_jmp;
      pc_val = {din, adr_lo};
      nk = is_lda ? k_read : (is_sta ? k_write : k_fetch);
      na = {din, adr_lo};
      nd = rf_r[`IDX_ACC];
    end
    if (is_lda && mc_r == 2'd3)
    begin
      rf_we = 1'b1;
      rf_idx = `IDX_ACC;
    end
    if ((is_ldax || is_stax) && mc_r == 2'd0)
    begin
      nk = is_ldax ? k_read : k_write;
      na = rp_adr;
      nd = rf_r[`IDX_ACC];
    end
    if (is_pchl)
    begin
      pc_ld = 1'b1;
      pc_val = hl;
    end
    // vector call pushes the return address high byte first
    if (is_rst && mc_r != 2'd2 && mc_r != 2'd3)
    begin
      nk = k_write;
      na = sp_r - 16'h0001;
      nd = (mc_r == 2'd0) ? pc_r[15:8] : pc_r[7:0];
      sp_dec = 1'b1;
      pc_ld = (mc_r == 2'd1);
      pc_val = {10'h000, dst, 3'h0};
    end
    // compare only sets flags, the accumulator keeps its value
    if (alu_go)
    begin
      fl_we = 1'b1;
      rf_we = (dst != `ALU_CMP);
      rf_idx = `IDX_ACC;
      rf_val = alu_res;
    end
  end

  // sequencer and cycle bookkeeping
  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      st_r <= st_t1;
      kind_r <= k_fetch;
      mc_r <= 2'd0;
      adr_r <= `PC_RST_VAL;
      wd_r <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
      if (cyc_end)
      begin
        kind_r <= nk;
        mc_r <= (nk == k_fetch) ? 2'd0 : mc_r + 2'd1;
        adr_r <= na;
        wd_r <= nd;
      end
    end
  end

  // program counter, opcode and operand latches
  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      pc_r <= `PC_RST_VAL;
      sp_r <= `SP_RST_VAL;
      ir_r <= 8'h00;
      lo_r <= 8'h00;
    end
    else
    begin
      if (st_r == st_t3 && kind_r == k_fetch)
      begin
        ir_r <= din;
        pc_r <= pc_r + 16'h0001;
      end
      else if (cyc_end && pc_ld)
        pc_r <= pc_val;
      else if (cyc_end && pc_up)
        pc_r <= pc_r + 16'h0001;
      if (cyc_end && sp_dec)
        sp_r <= sp_r - 16'h0001;
      if (cyc_end && lo_we)
        lo_r <= din;
    end
  end

  // register file, one flop byte per field code
  for (genvar i = 0; i < 8; i++)
  begin : g_rf
    always_ff @(posedge MCLK_I or posedge SYS_RST_I)
    begin
      if (SYS_RST_I)
        rf_r[i] <= `REG_RST_VAL;
      else if (cyc_end && rf_we && rf_idx == 3'(i))
        rf_r[i] <= rf_val;
    end
  end

  // flags change only on arithmetic, never on moves
  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      flag_r <= `FLAG_RST_VAL;
    else if (cyc_end && fl_we)
      flag_r <= alu_flags;
  end

  // bus strobes: address and strobe together from t2, strobe through t2 and t3, one byte each
  always_ff @(posedge MCLK_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      MEM_ADDR_O <= `PC_RST_VAL;
      MEM_WDATA_O <= 8'h00;
      MEM_RD_O <= 1'b0;
      MEM_WR_O <= 1'b0;
    end
    else if (st_r == st_t1)
    begin
      MEM_ADDR_O <= (kind_r == k_fetch) ? pc_r : adr_r;
      MEM_WDATA_O <= wd_r;
      MEM_RD_O <= (kind_r != k_write);
      MEM_WR_O <= (kind_r == k_write);
    end
    else if (st_r == st_t3)
    begin
      MEM_RD_O <= 1'b0;
      MEM_WR_O <= 1'b0;
    end
  end

  assign FLAGS_O = flag_r;
  assign ACC_O = rf_r[`IDX_ACC];

  a_flags_hold:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    cyc_end && is_xfer |=> $stable(flag_r)) else $error("flags changed on a move");
  a_fetch_walk:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    st_r == st_t1 && kind_r == k_fetch |=> st_r == st_t2 ##1 st_r == st_t3
    ##1 st_r == st_t4 ##1 st_r == st_t1) else $error("fetch not four states");
  a_pc_step:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    st_r == st_t3 && kind_r == k_fetch |=> pc_r == $past(pc_r) + 16'h0001)
    else $error("pc did not step after fetch");
  a_strobe_len:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    $rose(MEM_RD_O) |-> MEM_RD_O[*2] ##1 !MEM_RD_O) else $error("read strobe length");
  a_copy_reg:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    cyc_end && mov_rr |=> rf_r[$past(dst)] == $past(src_val))
    else $error("register copy lost");
  a_hl_read:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    cyc_end && mov_ld && mc_r == 2'd0 |-> ##2 (MEM_ADDR_O == $past(hl, 2)) ##1 MEM_RD_O)
    else $error("memory read not at pair address");
  a_hl_write:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    cyc_end && mov_st && mc_r == 2'd0 |-> ##2 (MEM_WDATA_O == $past(src_val, 2))
    ##1 MEM_WR_O) else $error("memory write data wrong");
  a_jump_tgt:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    cyc_end && is_jmp && mc_r == 2'd2 |=> pc_r == {$past(din), $past(lo_r)})
    else $error("jump target wrong");
  a_rst_vec:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    cyc_end && is_rst && mc_r == 2'd1 |=> pc_r == {10'h000, $past(dst), 3'h0})
    else $error("vector target wrong");
  a_zero_flag:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    cyc_end && fl_we |=> flag_r[`FLG_Z] == ($past(alu_res) == 8'h00))
    else $error("zero flag wrong");
  a_parity_flag:
  assert property (@(posedge MCLK_I) disable iff (SYS_RST_I)
    cyc_end && fl_we |=> flag_r[`FLG_P] == ~^$past(alu_res)) else $error("parity wrong");
endmodule

// >>> dv/byte_mem_model.sv
// byte_mem_model: 64K byte memory seen over the core's processor bus
// assumes strobe, address and write data are registers held for the whole cycle
module byte_mem_model (
  // clock
  input wire logic clk_i,
  // processor bus
  input wire cpu_core_pkg::addr_t addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire cpu_core_pkg::byte_t wdata_i,
  output cpu_core_pkg::byte_t rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_core_pkg::*;
  byte_t mem [0:65535];
  byte_t last_r;
  // answers at once, no wait states; idle bus shows junk so a late sample gets caught
  assign rdata_o = rd_i ? mem[addr_i] : ~last_r;
  // one byte per strobed cycle
  always @(posedge clk_i)
  begin
    if (rd_i)
      last_r <= mem[addr_i];
    if (wr_i)
      mem[addr_i] <= wdata_i;
  end
endmodule

// >>> dv/cpu_data_move_and_flags_tb.sv
// cpu_data_move_and_flags_tb: small programs run on the core against a byte memory
// assumes one clock per processor state and an all-zero core after reset
module cpu_data_move_and_flags_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cpu_core_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  addr_t mem_addr;
  logic mem_rd;
  logic mem_wr;
  byte_t mem_wdata;
  byte_t mem_rdata;
  byte_t acc;
  logic [4:0] flags;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;

  cpu_data_move cpu_data_move_inst (
    .MCLK_I(mclk), .SYS_RST_I(sys_rst), .MEM_ADDR_O(mem_addr), .MEM_RD_O(mem_rd),
    .MEM_WR_O(mem_wr), .MEM_WDATA_O(mem_wdata), .MEM_RDATA_I(mem_rdata),
    .FLAGS_O(flags), .ACC_O(acc));
  byte_mem_model byte_mem_model_inst (
    .clk_i(mclk), .addr_i(mem_addr), .rd_i(mem_rd), .wr_i(mem_wr),
    .wdata_i(mem_wdata), .rdata_o(mem_rdata));

  // clock and hang guard; whole run needs under 2000 cycles
  always #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  task wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic byte_t mb(input int a);
    return byte_mem_model_inst.mem[a];
  endfunction

  task load(input int a, input byte_t p[$]);
    foreach (p[i])
      byte_mem_model_inst.mem[a + i] = p[i];
  endtask

  // reset held while memory is wiped, so old bytes cannot hide a missed write
  task start(input byte_t p[$]);
    sys_rst <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 65536; i++)
      byte_mem_model_inst.mem[i] = 8'h00;
    load(0, p);
  endtask

  task go(input int n);
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  // read strobe rises give state counts of copy, copy from memory, immediate and jump
  task t_timing();
    logic [23:0] tw [9];
    int rt [$];
    addr_t ra [$];
    logic prev;
    tw = '{24'h000000, 24'h040001, 24'h080000, 24'h0b0002, 24'h0f0003,
      24'h120004, 24'h160005, 24'h190006, 24'h1c0004};
    start('{8'h41, 8'h7e, 8'h3e, 8'h5a, 8'hc3, 8'h04, 8'h00});
    @(negedge mclk);
    chk({mem_rd, mem_wr, 1'b0, flags, acc}, 16'h0000);
    chk(mem_addr, 16'h0000);
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    prev = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge mclk);
      if (mem_rd && !prev)
      begin
        rt.push_back(i);
        ra.push_back(mem_addr);
      end
      prev = mem_rd;
    end
    for (int k = 0; k < 9; k++)
    begin
      chk(16'(rt[k] - rt[0]), {8'h00, tw[k][23:16]});
      chk(ra[k], tw[k][15:0]);
    end
    chk({8'h00, acc}, 16'h005a);
  endtask

  // add, subtract and compare immediates on edge values of every flag
  task t_flags();
    logic [23:0] fc [7];
    byte_t a;
    byte_t b;
    byte_t r;
    logic [8:0] w;
    logic [4:0] h;
    logic sub;
    fc = '{24'h0fc601, 24'hffc601, 24'h40c640, 24'h05d607, 24'h33d633, 24'h80d601,
      24'h10fe20};
    for (int k = 0; k < 7; k++)
    begin
      a = fc[k][23:16];
      b = fc[k][7:0];
      sub = fc[k][15:8] != 8'hc6;
      w = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
      h = {1'b0, a[3:0]} + (sub ? {1'b0, ~b[3:0]} + 5'h01 : {1'b0, b[3:0]});
      r = (fc[k][15:8] == 8'hfe) ? a : w[7:0];
      start('{8'h3e, a, fc[k][15:8], b, 8'hc3, 8'h04, 8'h00});
      go(40);
      chk({8'h00, acc}, {8'h00, r});
      chk({11'h0, flags}, {11'h0, w[7], w[7:0] == 8'h00, h[4], ~^w[7:0], w[8]});
    end
  endtask

  // all register fields, copies to and from memory, direct and pair addressing
  task t_moves();
    byte_t ex [9];
    ex = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h40, 8'h05, 8'ha5, 8'h96, 8'h3c};
    start('{8'h3e, 8'hff, 8'hc6, 8'h01, 8'h06, 8'h11, 8'h0e, 8'h22, 8'h16, 8'h33,
      8'h1e, 8'h44, 8'h26, 8'h40, 8'h2e, 8'h00, 8'h70, 8'h2e, 8'h01, 8'h71,
      8'h2e, 8'h02, 8'h72, 8'h2e, 8'h03, 8'h73, 8'h2e, 8'h04, 8'h74, 8'h2e,
      8'h05, 8'h75, 8'h2e, 8'h06, 8'h36, 8'ha5, 8'h2e, 8'h10, 8'h7e, 8'h47,
      8'h2e, 8'h07, 8'h70, 8'h32, 8'h00, 8'h50, 8'h3a, 8'h20, 8'h40, 8'h16,
      8'h40, 8'h1e, 8'h08, 8'h12, 8'h3e, 8'h00, 8'h1a, 8'hc3, 8'h39, 8'h00});
    load(16'h4010, '{8'h96});
    load(16'h4020, '{8'h3c});
    go(400);
    for (int k = 0; k < 9; k++)
      chk({8'h00, mb(16'h4000 + k)}, {8'h00, ex[k]});
    chk({8'h00, mb(16'h5000)}, 16'h0096);
    chk({8'h00, acc}, 16'h003c);
    chk({11'h0, flags}, 16'h000f);
  endtask

  // direct jump then pair jump; fall-through code leaves a wrong marker
  task t_branch();
    start('{8'hc3, 8'h00, 8'h03, 8'h3e, 8'hee, 8'h32, 8'h00, 8'h60});
    load(16'h0300, '{8'h26, 8'h04, 8'h2e, 8'h10, 8'he9, 8'h3e, 8'hee});
    load(16'h0410, '{8'h3e, 8'h99, 8'h32, 8'h00, 8'h60, 8'hc3, 8'h15, 8'h04});
    go(120);
    chk({8'h00, acc}, 16'h0099);
    chk({8'h00, mb(16'h6000)}, 16'h0099);
  endtask

  // register subtract, add from memory, register compare; compare keeps the accumulator
  task t_alu_reg();
    start('{8'h3e, 8'h35, 8'h06, 8'h12, 8'h90, 8'h26, 8'h40, 8'h2e, 8'h00, 8'h86,
      8'hb8, 8'hc3, 8'h0b, 8'h00});
    load(16'h4000, '{8'h0d});
    go(80);
    chk({8'h00, acc}, 16'h0030);
    chk({11'h0, flags}, 16'h0002);
  endtask

  // every nonzero vector number, with the pushed return address
  task t_vector();
    for (int n = 1; n < 8; n++)
    begin
      start('{8'(8'hc7 + 8 * n), 8'h3e, 8'hee, 8'hc3, 8'h03, 8'h00});
      load(n * 8, '{8'h3e, 8'(8'h10 + n), 8'hc3, 8'(n * 8 + 2), 8'h00});
      go(50);
      chk({8'h00, acc}, 16'(8'h10 + n));
      chk({mb(16'hffff), mb(16'hfffe)}, 16'h0001);
    end
  endtask

  initial
  begin
    t_timing();
    t_flags();
    t_moves();
    t_branch();
    t_vector();
    t_alu_reg();
    wrap_up();
  end
endmodule
